// *** verilog/ssr_pkg.sv ***
// ============================================================
// Register map and field layout
package ssr_pkg;

   // ============================================================
   // Addresses: low nibble is the base, bit 4 selects the alias
   localparam int ADDR_W = 5;
   localparam int ALIAS_BIT = 4;
   localparam logic [3:0] BASE_MOTOR_CONTROL = 4'h1;
   localparam logic [3:0] BASE_CURRENT_LEVELS = 4'h2;
   localparam logic [3:0] BASE_DRIVE_MODE = 4'h3;
   localparam logic [3:0] BASE_SPEED_THRESHOLD = 4'h5;
   localparam logic [3:0] BASE_UNDERVOLTAGE = 4'h6;
   localparam logic [3:0] BASE_INTERRUPT_ENABLES = 4'h7;
   localparam logic [3:0] BASE_TRANSLATOR_POSITION = 4'hA;
   localparam logic [3:0] BASE_BEMF_RESULT = 4'hB;
   localparam logic [4:0] ADDR_STALL_TIMEOUT = 5'h04;
   localparam logic [4:0] ADDR_OPEN_COIL_CONFIG = 5'h14;

   // ============================================================
   // Reset values
   localparam logic [7:0] RST_MOTOR_CONTROL = 8'h00;
   localparam logic [7:0] RST_CURRENT_LEVELS = 8'h00;
   localparam logic [7:0] RST_DRIVE_MODE = 8'h20;
   localparam logic [7:0] RST_STALL_TIMEOUT = 8'h10;
   localparam logic [7:0] RST_SPEED_THRESHOLD = 8'h00;
   localparam logic [7:0] RST_UNDERVOLTAGE = 8'h00;
   localparam logic [7:0] RST_INTERRUPT_ENABLES = 8'h00;
   localparam logic [7:0] RST_OPEN_COIL_CONFIG = 8'h04;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ============================================================
   // Field positions
   localparam int MC_DIRECTION_POLARITY = 7;
   localparam int MC_RUNHOLD_POLARITY = 6;
   localparam int MC_SOFT_NEXT_STEP = 5;
   localparam int MC_MOTOR_ENABLE = 4;
   localparam int DM_ENHANCED_EMF = 7;
   localparam int DM_AUTO_DIAG = 6;
   localparam int DM_SLEEP_REQUEST = 3;
   localparam int OC_BOOST = 4;
   localparam int OC_KEEP_ACTIVE = 1;
   localparam int OC_ALL_OFF = 0;
   localparam int BR_PARITY = 7;
   localparam int BR_COIL = 6;
   localparam int BR_SIGN = 5;
   localparam int CMD_WRITE_BIT = 7;

   // ============================================================
   // Serial framing
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
   localparam logic [CNT_W-1:0] BYTE_BITS = 6'h08;
   localparam logic [CNT_W-1:0] FRAME_BITS = 6'h10;
   localparam logic [2:0] BYTE_PHASE_ZERO = 3'h0;
   localparam logic [3:0] FRAME_PHASE_ZERO = 4'h0;
   localparam logic [3:0] FIELD_ZERO = 4'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ============================================================
   // Control fields handed to the motor logic
   typedef struct packed {
      logic [3:0] stallThreshold;
      logic [3:0] holdCurrent;
      logic [3:0] runCurrent;
      logic enhancedEmfEnable;
      logic [1:0] slopeSelect;
      logic sleepRequest;
      logic [2:0] stepMode;
      logic [7:0] stallTimeoutValue;
      logic [7:0] speedThreshold;
      logic [3:0] undervoltOneLevel;
      logic [3:0] undervoltTwoLevel;
      logic [7:0] interruptEnables;
      logic currentBoost;
      logic [1:0] openTimeoutSelect;
   } ssr_drive_ctrl_t;

endpackage : ssr_pkg

// *** verilog/ssr_register_bank.sv ***
`timescale 1ns/1ps
module ssr_register_bank
   import ssr_pkg::*;
#(
   parameter int OPEN_TIMEOUT_0 = 1000,
   parameter int OPEN_TIMEOUT_1 = 5000,
   parameter int OPEN_TIMEOUT_2 = 10000,
   parameter int OPEN_TIMEOUT_3 = 40000,
   parameter int STALL_TICK_CYCLES = 250,
   parameter int OPEN_CNT_W = 24
) (
   input wire logic clk, // 250 MHz core clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic spiClk, // Serial clock pin
   input wire logic spiCsB, // Chip select pin, active low
   input wire logic spiDi, // Serial data in pin
   output logic spiDoOut, // Open-drain data out level, always low
   output logic spiDoOe, // High while data out is pulled low
   input wire logic dirPin, // Direction pin
   input wire logic runholdPin, // Run/hold pin
   input wire logic nextStepPin, // Next-step pin
   input wire logic [6:0] microstepPos, // Translator position
   input wire logic measured_coil, // Coil of last back-EMF sample
   input wire logic bemfSign, // Sign of last back-EMF sample
   input wire logic [4:0] bemfValue, // Last back-EMF value
   input wire logic [7:0] speedValue, // Internal speed value
   input wire logic fullStepTick, // One pulse per full step
   input wire logic [1:0] pwmFull, // Duty at full scale, Y in bit 1
   output ssr_drive_ctrl_t driveCtrl, // Control fields
   output logic direction, // Effective direction
   output logic hold, // Hold status
   output logic stepPulse, // Advance translator one step
   output logic bridgeXEn, // Bridge X enable
   output logic bridgeYEn, // Bridge Y enable
   output logic stallDetectEn, // Back-EMF and stall measurement enable
   output logic bemfSampleReq, // Take a stall back-EMF sample
   output logic diagStart, // Start automatic diagnostic
   output logic [1:0] openCoil, // Open coil flags, Y in bit 1
   output logic spiFrameError // Last frame not 0, 16, 32 or 48 bits (count saturates at 63)
);

   // ============================================================
   // State
   typedef struct packed {
      logic [2:0] clkSync;
      logic [2:0] csbSync;
      logic [1:0] diSync;
      logic [1:0] dirSync;
      logic [1:0] rhbSync;
      logic [2:0] nxtSync;
      logic [CNT_W-1:0] bitCnt;
      logic [7:0] rxShift;
      logic [7:0] txShift;
      logic doBit;
      logic [ADDR_W-1:0] addr;
      logic wrReq;
      logic [7:0] wrData;
      logic [7:0] motorControl;
      logic [7:0] currentLevels;
      logic [7:0] driveMode;
      logic [7:0] stallTimeout;
      logic [7:0] speedThreshold;
      logic [7:0] undervoltage;
      logic [7:0] interruptEnables;
      logic [7:0] openCoilConfig;
      logic [1:0][OPEN_CNT_W-1:0] openCnt;
      logic [1:0] openFlag;
      logic [15:0] stallPrescale;
      logic [7:0] stallCnt;
      logic stallArmed;
      logic doOe;
      logic frameError;
      logic direction;
      logic hold;
      logic stepPulse;
      logic bridgeXEn;
      logic bridgeYEn;
      logic stallDetectEn;
      logic bemfSampleReq;
      logic diagStart;
   } ssr_state_t;

   ssr_state_t stateQ;
   ssr_state_t stateD;

   logic [OPEN_CNT_W-1:0] openLimit;
   logic [7:0] rxByte;
   logic [CNT_W-1:0] cntNext;
   logic clkRise;
   logic clkFall;
   logic csbFall;
   logic csbRise;
   logic csbLow;
   logic stallEn;
   logic [7:0] rdCur;

   // ============================================================
   // Read mux; aliases share one store, two registers have no alias
   function automatic logic [7:0] readReg(input logic [ADDR_W-1:0] a, input ssr_state_t s);
      logic [7:0] bemfByte;
      logic [3:0] base;
      bemfByte = {1'b0, measured_coil, bemfSign, bemfValue};
      bemfByte[BR_PARITY] = ^bemfByte; // even parity
      base = a[3:0];
      readReg = READ_UNMAPPED;
      if (a == ADDR_STALL_TIMEOUT) begin
         readReg = s.stallTimeout;
      end else if (a == ADDR_OPEN_COIL_CONFIG) begin
         readReg = s.openCoilConfig;
      end else if (base == BASE_MOTOR_CONTROL) begin
         readReg = s.motorControl;
      end else if (base == BASE_CURRENT_LEVELS) begin
         readReg = s.currentLevels;
      end else if (base == BASE_DRIVE_MODE) begin
         readReg = s.driveMode;
      end else if (base == BASE_SPEED_THRESHOLD) begin
         readReg = s.speedThreshold;
      end else if (base == BASE_UNDERVOLTAGE) begin
         readReg = s.undervoltage;
      end else if (base == BASE_INTERRUPT_ENABLES) begin
         readReg = s.interruptEnables;
      end else if (base == BASE_TRANSLATOR_POSITION) begin
         readReg = {1'b0, microstepPos};
      end else if (base == BASE_BEMF_RESULT) begin
         readReg = bemfByte;
      end
   endfunction : readReg

   // ============================================================
   // Open timeout chosen by the two-bit select field
   always_comb begin
      case (stateQ.openCoilConfig[3:2])
         2'h0: openLimit = OPEN_CNT_W'(OPEN_TIMEOUT_0);
         2'h1: openLimit = OPEN_CNT_W'(OPEN_TIMEOUT_1);
         2'h2: openLimit = OPEN_CNT_W'(OPEN_TIMEOUT_2);
         default: openLimit = OPEN_CNT_W'(OPEN_TIMEOUT_3);
      endcase
   end

   // ============================================================
   // Next state
   always_comb begin
      stateD = stateQ;
      rdCur = readReg(stateQ.addr, stateQ); // Reply at the remembered address
      // Pins pass two flops before any logic looks at them
      stateD.clkSync = {stateQ.clkSync[1:0], spiClk};
      stateD.csbSync = {stateQ.csbSync[1:0], spiCsB};
      stateD.diSync = {stateQ.diSync[0], spiDi};
      stateD.dirSync = {stateQ.dirSync[0], dirPin};
      stateD.rhbSync = {stateQ.rhbSync[0], runholdPin};
      stateD.nxtSync = {stateQ.nxtSync[1:0], nextStepPin};
      clkRise = stateQ.clkSync[1] & ~stateQ.clkSync[2];
      clkFall = ~stateQ.clkSync[1] & stateQ.clkSync[2];
      csbFall = ~stateQ.csbSync[1] & stateQ.csbSync[2];
      csbRise = stateQ.csbSync[1] & ~stateQ.csbSync[2];
      csbLow = ~stateQ.csbSync[1];
      rxByte = {stateQ.rxShift[6:0], stateQ.diSync[1]};
      cntNext = (stateQ.bitCnt == CNT_MAX) ? CNT_MAX : stateQ.bitCnt + CNT_ONE;
      stateD.stepPulse = stateQ.nxtSync[1] & ~stateQ.nxtSync[2]; // Pin edge, sync delay accepted
      stateD.diagStart = 1'b0;
      stateD.bemfSampleReq = 1'b0;

      // Frame start: first byte out is the register at the remembered address
      if (csbFall) begin
         stateD.bitCnt = CNT_ZERO;
         stateD.doBit = rdCur[7];
         stateD.txShift = {rdCur[6:0], 1'b0};
         stateD.driveMode[DM_SLEEP_REQUEST] = 1'b0; // Chip select falling wakes the device
      end else if (csbLow && clkRise) begin
         stateD.rxShift = rxByte;
         stateD.bitCnt = cntNext;
         if (cntNext[2:0] == BYTE_PHASE_ZERO) begin
            if (cntNext == BYTE_BITS) begin
               // Command byte: write flag and address, then reply from it
               stateD.addr = rxByte[ADDR_W-1:0];
               stateD.wrReq = rxByte[CMD_WRITE_BIT];
               stateD.txShift = readReg(rxByte[ADDR_W-1:0], stateQ);
            end else begin
               if (cntNext == FRAME_BITS) begin
                  stateD.wrData = rxByte;
               end
               stateD.txShift = readReg(stateQ.addr, stateQ);
            end
         end
      end else if (csbLow && clkFall) begin
         stateD.doBit = stateQ.txShift[7];
         stateD.txShift = {stateQ.txShift[6:0], 1'b0};
      end
      stateD.doOe = csbLow & ~stateD.doBit;

      // Frame end: commit only a clean 16-bit write
      if (csbRise) begin
         stateD.frameError = (stateQ.bitCnt[3:0] != FRAME_PHASE_ZERO);
         if (stateQ.bitCnt == FRAME_BITS && stateQ.wrReq) begin
            if (stateQ.addr == ADDR_STALL_TIMEOUT) begin
               stateD.stallTimeout = stateQ.wrData;
            end else if (stateQ.addr == ADDR_OPEN_COIL_CONFIG) begin
               stateD.openCoilConfig = {3'h0, stateQ.wrData[4:0]};
            end else if (stateQ.addr[3:0] == BASE_MOTOR_CONTROL) begin
               stateD.motorControl = stateQ.wrData;
               stateD.stepPulse = stateQ.wrData[MC_SOFT_NEXT_STEP];
               stateD.diagStart = stateQ.driveMode[DM_AUTO_DIAG] & stateQ.wrData[MC_MOTOR_ENABLE] &
                  ~stateQ.motorControl[MC_MOTOR_ENABLE];
               if (stateQ.wrData[MC_MOTOR_ENABLE]) begin
                  stateD.openFlag = 2'h0; // Re-enable clears open flags
               end
            end else if (stateQ.addr[3:0] == BASE_CURRENT_LEVELS) begin
               stateD.currentLevels = stateQ.wrData;
            end else if (stateQ.addr[3:0] == BASE_DRIVE_MODE) begin
               stateD.driveMode = stateQ.wrData;
            end else if (stateQ.addr[3:0] == BASE_SPEED_THRESHOLD) begin
               stateD.speedThreshold = stateQ.wrData;
            end else if (stateQ.addr[3:0] == BASE_UNDERVOLTAGE) begin
               stateD.undervoltage = stateQ.wrData;
            end else if (stateQ.addr[3:0] == BASE_INTERRUPT_ENABLES) begin
               stateD.interruptEnables = stateQ.wrData;
            end
         end
      end

      // Open coil watch; detection wins over a clear in the same cycle
      for (int i = 0; i < 2; i++) begin
         if (pwmFull[i] && stateQ.motorControl[MC_MOTOR_ENABLE]) begin
            if (stateQ.openCnt[i] >= openLimit) begin
               stateD.openFlag[i] = 1'b1;
            end else begin
               stateD.openCnt[i] = stateQ.openCnt[i] + OPEN_CNT_W'(1);
            end
         end else begin
            stateD.openCnt[i] = '0;
         end
      end
      if ((stateD.openFlag & ~stateQ.openFlag) != 2'h0 && stateQ.openCoilConfig[OC_ALL_OFF] &&
         !stateQ.openCoilConfig[OC_KEEP_ACTIVE]) begin
         stateD.motorControl[MC_MOTOR_ENABLE] = 1'b0;
      end

      // Stall timeout in ticks since the last full step
      stallEn = (stateQ.motorControl[3:0] != FIELD_ZERO) && (speedValue <= stateQ.speedThreshold);
      if (fullStepTick) begin
         stateD.stallPrescale = '0;
         stateD.stallCnt = BYTE_ZERO;
         stateD.stallArmed = 1'b1;
      end else if (stateQ.stallPrescale == 16'(STALL_TICK_CYCLES - 1)) begin
         stateD.stallPrescale = '0;
         if (stateQ.stallCnt != stateQ.stallTimeout) begin
            stateD.stallCnt = stateQ.stallCnt + 8'h01;
         end
      end else begin
         stateD.stallPrescale = stateQ.stallPrescale + 16'h0001;
      end
      if (stateQ.stallArmed && stateQ.stallCnt == stateQ.stallTimeout) begin
         stateD.stallArmed = 1'b0;
         stateD.bemfSampleReq = stallEn;
      end

      // Registered pin-facing results
      stateD.direction = stateQ.dirSync[1] ^ stateQ.motorControl[MC_DIRECTION_POLARITY];
      stateD.hold = ~(stateQ.rhbSync[1] ^ stateQ.motorControl[MC_RUNHOLD_POLARITY]);
      stateD.bridgeXEn = stateD.motorControl[MC_MOTOR_ENABLE] & ~stateD.driveMode[DM_SLEEP_REQUEST] &
         (~stateD.openFlag[0] | stateD.openCoilConfig[OC_KEEP_ACTIVE]);
      stateD.bridgeYEn = stateD.motorControl[MC_MOTOR_ENABLE] & ~stateD.driveMode[DM_SLEEP_REQUEST] &
         (~stateD.openFlag[1] | stateD.openCoilConfig[OC_KEEP_ACTIVE]);
      stateD.stallDetectEn = stallEn;
   end

   // ============================================================
   // Registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stateQ <= '0;
         stateQ.clkSync <= 3'h0;
         stateQ.csbSync <= 3'h7; // Idle high, no false frame at release
         stateQ.motorControl <= RST_MOTOR_CONTROL;
         stateQ.currentLevels <= RST_CURRENT_LEVELS;
         stateQ.driveMode <= RST_DRIVE_MODE;
         stateQ.stallTimeout <= RST_STALL_TIMEOUT;
         stateQ.speedThreshold <= RST_SPEED_THRESHOLD;
         stateQ.undervoltage <= RST_UNDERVOLTAGE;
         stateQ.interruptEnables <= RST_INTERRUPT_ENABLES;
         stateQ.openCoilConfig <= RST_OPEN_COIL_CONFIG;
         stateQ.hold <= 1'b0;
      end else begin
         stateQ <= stateD;
      end
   end

   // ============================================================
   // Outputs, all straight from the state flops
   assign spiDoOut = stateQ.rxShift[0] & 1'b0; // Open drain only ever pulls low
   assign spiDoOe = stateQ.doOe;
   assign direction = stateQ.direction;
   assign hold = stateQ.hold;
   assign stepPulse = stateQ.stepPulse;
   assign bridgeXEn = stateQ.bridgeXEn;
   assign bridgeYEn = stateQ.bridgeYEn;
   assign stallDetectEn = stateQ.stallDetectEn;
   assign bemfSampleReq = stateQ.bemfSampleReq;
   assign diagStart = stateQ.diagStart;
   assign openCoil = stateQ.openFlag;
   assign spiFrameError = stateQ.frameError;

   // Control fields for the motor logic
   assign driveCtrl.stallThreshold = stateQ.motorControl[3:0];
   assign driveCtrl.holdCurrent = stateQ.currentLevels[7:4];
   assign driveCtrl.runCurrent = stateQ.currentLevels[3:0];
   assign driveCtrl.enhancedEmfEnable = stateQ.driveMode[DM_ENHANCED_EMF];
   assign driveCtrl.slopeSelect = stateQ.driveMode[5:4];
   assign driveCtrl.sleepRequest = stateQ.driveMode[DM_SLEEP_REQUEST];
   assign driveCtrl.stepMode = stateQ.driveMode[2:0];
   assign driveCtrl.stallTimeoutValue = stateQ.stallTimeout;
   assign driveCtrl.speedThreshold = stateQ.speedThreshold;
   assign driveCtrl.undervoltOneLevel = stateQ.undervoltage[7:4];
   assign driveCtrl.undervoltTwoLevel = stateQ.undervoltage[3:0];
   assign driveCtrl.interruptEnables = stateQ.interruptEnables;
   assign driveCtrl.currentBoost = stateQ.openCoilConfig[OC_BOOST];
   assign driveCtrl.openTimeoutSelect = stateQ.openCoilConfig[3:2];

endmodule : ssr_register_bank

// *** verification/ssr_register_bank_assertions.sv ***
`timescale 1ns/1ps
// ============================================================
// Port-level checks on the register bank
module ssr_rb_checker
   import ssr_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic rst_b, // Sync reset, active low
   input wire logic spiCsB, // Chip select
   input wire logic dirPin, // Direction pin
   input wire logic runholdPin, // Run/hold pin
   input wire logic [1:0] pwmFull, // Full duty flags
   input wire logic [7:0] speedValue, // Speed value
   input ssr_drive_ctrl_t driveCtrl, // Control fields
   input wire logic direction, // Effective direction
   input wire logic hold, // Hold status
   input wire logic stepPulse, // Step pulse
   input wire logic bridgeXEn, // Bridge X enable
   input wire logic bridgeYEn, // Bridge Y enable
   input wire logic stallDetectEn, // Stall enable
   input wire logic bemfSampleReq, // Stall sample pulse
   input wire logic diagStart, // Diagnostic start
   input wire logic [1:0] openCoil, // Open flags
   input wire logic spiDoOe // Data out pull
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ============================================================
   // Pins change only with the bus idle, so polarity is steady meanwhile
   step_pulse_a: assert property (stepPulse |=> !stepPulse)
      else $error("step pulse longer than one cycle");
   stall_gate_a: assert property (stallDetectEn == ($past(driveCtrl.stallThreshold) != 4'h0 &&
      $past(speedValue) <= $past(driveCtrl.speedThreshold))) else $error("stall enable wrong");
   sleep_bridge_a: assert property (driveCtrl.sleepRequest && $past(driveCtrl.sleepRequest)
      |-> !bridgeXEn && !bridgeYEn) else $error("bridge on in sleep");
   diag_idle_a: assert property (diagStart |-> spiCsB)
      else $error("diagnostic start inside a frame");
   dir_flip_a: assert property ($changed(dirPin) ##1 (spiCsB && $stable(dirPin))[*6]
      |-> direction != $past(direction, 6)) else $error("direction did not follow pin");
   hold_flip_a: assert property ($changed(runholdPin) ##1 (spiCsB && $stable(runholdPin))[*6]
      |-> hold != $past(hold, 6)) else $error("hold did not follow pin");
   do_release_a: assert property (spiCsB[*6] |-> !spiDoOe)
      else $error("data out pulled while deselected");
   open_cause_a: assert property ($rose(openCoil[0]) |-> $past(pwmFull[0]))
      else $error("open flag without full duty");
   sample_gate_a: assert property (bemfSampleReq |-> driveCtrl.stallThreshold != 4'h0)
      else $error("stall sample while disabled");
   cover property (diagStart);
   cover property ($rose(openCoil[0]));
   cover property (stallDetectEn);
   cover property (bemfSampleReq);
endmodule : ssr_rb_checker

bind ssr_register_bank ssr_rb_checker u_chk (.clk, .rst_b, .spiCsB, .dirPin, .runholdPin, .pwmFull, .speedValue,
   .driveCtrl, .direction, .hold, .stepPulse, .bridgeXEn, .bridgeYEn, .stallDetectEn, .bemfSampleReq, .diagStart,
   .openCoil, .spiDoOe);

// *** verification/ssr_spi_host.sv ***
`timescale 1ns/1ps
// ============================================================
// Host side of the serial link
module ssr_spi_host (
   input wire logic clk, // Core clock for pacing
   input wire logic spiDoOe, // Device pulls data out low
   output logic spiClk, // Serial clock, still between frames
   output logic spiCsB, // Chip select, active low
   output logic spiDi, // Serial data to device
   output logic [15:0] rxWord, // Bits read in the last frame
   output logic rxDone // Toggles as each frame ends
);
   // Idle levels
   initial begin
      spiClk = 1'b0;
      spiCsB = 1'b1;
      spiDi = 1'b0;
      rxWord = 16'h0000;
      rxDone = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   // Half period of 10 cycles, well above the 3-cycle minimum
   task automatic frame(input logic [15:0] tx, input int nb);
      wt(1);
      spiCsB = 1'b0;
      for (int i = 0; i < nb; i++) begin
         spiDi = tx[15-i];
         wt(10);
         rxWord = {rxWord[14:0], ~spiDoOe}; // Pull-up when released
         spiClk = 1'b1;
         wt(10);
         spiClk = 1'b0;
      end
      wt(10);
      spiCsB = 1'b1;
      spiDi = ~spiDi; // Released line must not look held
      wt(8);
      rxDone = ~rxDone;
   endtask : frame
endmodule : ssr_spi_host

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import ssr_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, spiClk, spiCsB, spiDi, spiDoOut, spiDoOe, rxDone, fullStepTick = 1'b0;
   logic dirPin = 1'b0, runholdPin = 1'b0, nextStepPin = 1'b0, measured_coil, bemfSign;
   logic direction, hold, stepPulse, bridgeXEn, bridgeYEn, stallDetectEn, bemfSampleReq, diagStart, spiFrameError;
   logic [6:0] microstepPos;
   logic [4:0] bemfValue, la;
   logic [7:0] speedValue = 8'h00, m [32];
   logic [1:0] pwmFull = 2'b00, openCoil;
   logic [15:0] rxWord;
   logic [31:0] q[$], e, r;
   ssr_drive_ctrl_t driveCtrl;
   int mismatches = 0, n_tests = 0, seed = 7, steps = 0, diags = 0, samples = 0, steps0, diags0;
   always #2 clk = ~clk;
   ssr_register_bank #(.OPEN_TIMEOUT_0(4), .OPEN_TIMEOUT_1(8), .OPEN_TIMEOUT_2(12), .OPEN_TIMEOUT_3(16),
      .STALL_TICK_CYCLES(2)) DUT (.clk, .rst_b, .spiClk, .spiCsB, .spiDi, .spiDoOut, .spiDoOe, .dirPin,
      .runholdPin, .nextStepPin, .microstepPos, .measured_coil, .bemfSign, .bemfValue, .speedValue, .fullStepTick,
      .pwmFull, .driveCtrl, .direction, .hold, .stepPulse, .bridgeXEn, .bridgeYEn, .stallDetectEn,
      .bemfSampleReq, .diagStart, .openCoil, .spiFrameError);
   ssr_spi_host host (.clk, .spiDoOe, .spiClk, .spiCsB, .spiDi, .rxWord, .rxDone);
   // ============================================================
   // Shared checking
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   // Aliased registers fold onto their base slot
   function automatic logic [4:0] base(input logic [4:0] a);
      return (a[3:0] inside {1, 2, 3, 5, 6, 7, 10, 11}) ? {1'b0, a[3:0]} : a;
   endfunction : base
   function automatic ssr_drive_ctrl_t ec();
      return {m[1][3:0], m[2], m[3][7], m[3][5:0], m[4], m[5], m[6], m[7], m[20][4:2]};
   endfunction : ec
   // Fresh random position and back-EMF inputs, mirrored into the model
   task automatic new_inputs();
      r = $random(seed);
      {microstepPos, measured_coil, bemfSign, bemfValue} = r[13:0];
      m[10] = {1'b0, microstepPos};
      m[11] = {^{measured_coil, bemfSign, bemfValue}, measured_coil, bemfSign, bemfValue};
   endtask : new_inputs
   // Note the expected reply, run the frame, then update the model
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] d, input logic [15:0] msk, input int nb);
      q.push_back({msk, m[base(la)], m[base(cmd[4:0])]});
      la = cmd[4:0];
      host.frame({cmd, d}, nb);
      if (nb == 16 && cmd[7] && base(la) inside {1, 2, 3, 4, 5, 6, 7, 20}) m[base(la)] = base(la) == 20 ? d & 8'h1F : d;
   endtask : xfer
   // ============================================================
   // Reply monitor and pulse counters
   // Time-zero settling of the toggle is not a frame
   always @(rxDone) begin
      if (rst_b) begin
         e = q.pop_front();
         chk(rxWord & e[31:16], e[15:0] & e[31:16]);
      end
   end
   always @(posedge clk) begin
      steps <= steps + int'(stepPulse);
      diags <= diags + int'(diagStart);
      samples <= samples + int'(bemfSampleReq);
   end
   initial begin
      #300000;
      mismatches++;
      wrap_up();
   end
   // ============================================================
   // Main sequence
   initial begin
      m = '{default: 8'h00};
      {m[3], m[4], m[20]} = {RST_DRIVE_MODE, RST_STALL_TIMEOUT, RST_OPEN_COIL_CONFIG};
      new_inputs();
      la = 5'h00;
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      host.wt(4);
      xfer(8'h00, 8'h00, 16'h00FF, 16);
      for (int a = 1; a < 32; a++) xfer({3'b000, a[4:0]}, 8'h00, 16'hFFFF, 16);
      $display("Test reset_map done");
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         if (base(r[4:0]) == 5'h03) r[11] = 1'b0;
         xfer({3'b100, r[4:0]}, r[15:8], 16'hFFFF, 16);
      end
      new_inputs();
      for (int a = 1; a < 32; a++) xfer({3'b000, a[4:0]}, 8'h00, 16'hFFFF, 16);
      chk(driveCtrl, ec());
      $display("Test random_rw done");
      xfer(8'h82, 8'h3C, 16'h0000, 12);
      chk({spiFrameError, spiDoOut}, 2'b10);
      chk(driveCtrl, ec());
      xfer(8'h02, 8'h00, 16'hFFFF, 16);
      chk(spiFrameError, 1'b0);
      $display("Test short_frame done");
      xfer(8'h81, 8'h00, 16'hFFFF, 16);
      xfer(8'h83, 8'h40, 16'hFFFF, 16);
      {steps0, diags0} = {steps, diags};
      xfer(8'h81, 8'h30, 16'hFFFF, 16);
      chk({steps - steps0, diags - diags0}, {32'd1, 32'd1});
      chk({bridgeXEn, bridgeYEn}, 2'b11);
      nextStepPin = 1'b1;
      host.wt(10);
      nextStepPin = 1'b0;
      host.wt(10);
      chk(steps - steps0, 2);
      for (int p = 0; p < 4; p++) begin
         xfer(8'h81, {p[1], p[1], 6'h10}, 16'hFFFF, 16);
         {dirPin, runholdPin} = {p[0], p[0]};
         host.wt(8);
         chk({direction, hold}, {p[0] ^ p[1], ~(p[0] ^ p[1])});
      end
      $display("Test step_pins done");
      xfer(8'h83, 8'h08, 16'hFFFF, 16);
      chk({driveCtrl.sleepRequest, bridgeXEn, bridgeYEn}, 3'b100);
      m[3][3] = 1'b0;
      xfer(8'h03, 8'h00, 16'h00FF, 16);
      xfer(8'h85, 8'h80, 16'hFFFF, 16);
      speedValue = 8'h40;
      xfer(8'h81, 8'h13, 16'hFFFF, 16);
      chk(stallDetectEn, 1'b1);
      speedValue = 8'h81;
      host.wt(3);
      chk(stallDetectEn, 1'b0);
      // Short timeout; one sample at the threshold, none above it
      xfer(8'h84, 8'h05, 16'hFFFF, 16);
      for (int k = 0; k < 2; k++) begin
         speedValue = k ? 8'h81 : 8'h80;
         fullStepTick = 1'b1;
         host.wt(1);
         fullStepTick = 1'b0;
         host.wt(40);
         chk(samples, 1);
      end
      $display("Test sleep_stall done");
      xfer(8'h94, 8'h00, 16'hFFFF, 16);
      pwmFull = 2'b01;
      host.wt(12);
      chk({openCoil, bridgeYEn, bridgeXEn}, 4'b0110);
      pwmFull = 2'b00;
      xfer(8'h94, 8'h01, 16'hFFFF, 16);
      xfer(8'h81, 8'h10, 16'hFFFF, 16);
      pwmFull = 2'b10;
      host.wt(12);
      chk({openCoil, bridgeYEn, bridgeXEn}, 4'b1000);
      m[1][4] = 1'b0; // Hardware dropped motor enable
      xfer(8'h94, 8'h02, 16'hFFFF, 16);
      xfer(8'h81, 8'h10, 16'hFFFF, 16);
      host.wt(12);
      chk({openCoil, bridgeYEn, bridgeXEn}, 4'b1011);
      $display("Test open_coil done");
      wrap_up();
   end
endmodule : tb_top
